// file: hw/vci_consts.svh
// Offsets, field positions, reset values and build options of the block
`ifndef VCI_CONSTS_SVH
`define VCI_CONSTS_SVH

// Register byte offsets in the control frame
`define VCI_OFF_TYPE 12'h004
`define VCI_OFF_VMCTL 12'h008
`define VCI_OFF_MSTAT 12'h010

// Status bit positions
`define VCI_MS_EOI 0
`define VCI_MS_UNDER 1
`define VCI_MS_ABSENT 2
`define VCI_MS_NOPEND 3
`define VCI_MS_G0EN 4
`define VCI_MS_G0DIS 5
`define VCI_MS_G1EN 6
`define VCI_MS_G1DIS 7

// VM control fields
`define VCI_VM_PMASK_HI 31
`define VCI_VM_PMASK_LO 24
`define VCI_VM_BP0_HI 23
`define VCI_VM_BP0_LO 21
`define VCI_VM_BP1_HI 20
`define VCI_VM_BP1_LO 18
`define VCI_VM_SPLIT 9
`define VCI_VM_CBP 4
`define VCI_VM_FIQ 3
`define VCI_VM_ACK 2
`define VCI_VM_G1EN 1
`define VCI_VM_G0EN 0
// Writable bits; reserved bits 17:10 and 8:5 stay zero
`define VCI_VM_MASK 32'hfffc021f
// Reset value of the functional fields (undefined by the architecture)
`define VCI_VM_RESET 32'h00000000

// List entry state field and encodings
`define VCI_LR_ST_HI 29
`define VCI_LR_ST_LO 28
`define VCI_ST_INACT 2'h0
`define VCI_ST_PEND 2'h1
`define VCI_ST_ACT 2'h2
`define VCI_ST_ACTPEND 2'h3

// Type register build options
`define VCI_NUM_LR 4
`define VCI_PRI_M1 3'h4
`define VCI_PRE_M1 3'h4
`define VCI_IDW_16 3'h0
`define VCI_IDW_24 3'h1
`define VCI_SEI_SUP 1'b0
`define VCI_AFF3_SUP 1'b0
`define VCI_SPURIOUS_ID 10'h3fe

`endif

// file: hw/vci_pkg.sv
// Types shared by the virtual interface control block
`default_nettype none
package vci_pkg;
    typedef enum logic [1:0] {
        VCI_LR_INACTIVE,
        VCI_LR_PENDING,
        VCI_LR_ACTIVE,
        VCI_LR_ACT_PEND
    } vci_lr_state_t;
    typedef logic [31:0] vci_word_t;
endpackage
`default_nettype wire

// file: hw/vci_lr_scan.sv
// List entry scan: flags at most one valid entry and no pending entry
`default_nettype none
`include "vci_consts.svh"
module vci_lr_scan (
    input wire logic [`VCI_NUM_LR*32-1:0] list_entry_reg_i,
    output logic le_one_valid_o,
    output logic none_pending_o
);
    logic [`VCI_NUM_LR-1:0] valid_bit;
    logic [`VCI_NUM_LR-1:0] pend_bit;

    // Per entry decode of the two-bit state field
    genvar g;
    generate
        for (g = 0; g < `VCI_NUM_LR; g++) begin : g_ent
            logic [1:0] st;
            assign st = list_entry_reg_i[g*32+`VCI_LR_ST_HI -: 2];
            assign valid_bit[g] = (st != `VCI_ST_INACT);
            // Active-and-pending does not count as pending
            assign pend_bit[g] = (st == `VCI_ST_PEND);
        end
    endgenerate

    // Zero or one valid: clear the lowest set bit and test for empty
    assign le_one_valid_o =
        ((valid_bit & (valid_bit - 1'b1)) == '0);
    assign none_pending_o = (pend_bit == '0);
endmodule
`default_nettype wire

// file: hw/vci_ctrl_regs.sv
// Hypervisor view registers of the virtual CPU interface
`default_nettype none
`include "vci_consts.svh"
// How it works
// - Absent flag bit 2 set when its enable and end count nonzero.
// - Underflow bit 1 set when enabled and at most one entry valid.
// - EOI bit 0 set while any end-of-interrupt status bit is one.
// - Only state 01 counts as pending, not active-and-pending.
// - Priority mask bits 31:24; signal only priorities above the mask.
// - Group 0 binary point bits 23:21; also group 1 when common set.
// - Group 1 binary point bits 20:18 used when common bit clear.
// - Bit 9 splits priority drop from deactivate; may read as one.
// - Bit 4 selects which binary point governs group 1.
// - Bit 3 presents group 0 as fast interrupts when set.
// - Bit 2 clear makes group 1 acknowledge return identifier 1022.
// - Bits 1 and 0 enable groups 1 and 0, mirroring guest writes.
// - Control reserved bits read zero; functional reset value undefined.
// - Type bits 31:29 priority bits minus one, 28:26 preempt minus one.
// - Type bits 25:23 identifier width code: 000 16, 001 24 bits.
// - Type bit 22 reports system error interrupt support.
// - Type bit 21 reports nonzero top affinity support.
// - Type bits 4:0 list count minus one; 20:5 read zero.
// - Maintenance output high only with a status bit and global enable.
// - Entry state 00 inactive, 01 pending, 10 active, 11 both.
module vci_ctrl_regs #(
    parameter bit SPLIT_RAO = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Register frame port
    input wire logic reg_sel_i,
    input wire logic reg_wr_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // Hypervisor control and list state from outside
    input wire logic hyp_global_enable_i,
    input wire logic list_entry_absent_irq_enable_i,
    input wire logic underflow_irq_enable_i,
    input wire logic no_pending_irq_enable_i,
    input wire logic group0_state_irq_enable_i,
    input wire logic group1_state_irq_enable_i,
    input wire logic [4:0] end_of_irq_counter_i,
    input wire logic [31:0] eoi_status_vector_i,
    input wire logic [`VCI_NUM_LR*32-1:0] list_entry_reg_i,
    // Guest writes mirrored into the control register
    input wire logic guest_pmask_wr_i,
    input wire logic guest_binpoint_wr_i,
    input wire logic guest_alias_binpoint_wr_i,
    input wire logic guest_ctl_wr_i,
    input wire logic [31:0] guest_wdata_i,
    // Candidate interrupt for the virtual interface
    input wire logic cand_valid_i,
    input wire logic cand_group1_i,
    input wire logic [7:0] cand_priority_i,
    input wire logic [9:0] cand_id_i,
    // Derived behaviour
    output logic maint_irq_o,
    output logic virt_irq_o,
    output logic virt_fiq_o,
    output logic [9:0] ack_id_o,
    output logic [2:0] group1_binpoint_o,
    output logic eoi_deactivates_o
);
    vci_pkg::vci_word_t vm_control_alias;
    logic hyp_vm_wr;
    logic hyp_rd;
    logic [7:0] maintenance_irq_status;
    logic [7:0] next_status;
    logic le_one_valid;
    logic none_pending;
    vci_pkg::vci_word_t virtual_type_info;
    vci_pkg::vci_word_t next_rdata;
    logic virt_eoi_split_mode;
    logic virt_common_binpoint;
    logic virt_fast_irq_select;
    logic virt_ack_control;
    logic virt_group1_enable;
    logic virt_group0_enable;
    logic [7:0] virt_priority_mask;
    logic [2:0] virt_binary_point_g0;
    logic [2:0] virt_binary_point_g1;
    logic above_mask;
    logic group_on;
    // Reset image of the control word; its field values are a free choice
    localparam vci_pkg::vci_word_t VM_RESET_WORD = `VCI_VM_RESET;

    vci_lr_scan u_scan (
        .list_entry_reg_i(list_entry_reg_i),
        .le_one_valid_o(le_one_valid),
        .none_pending_o(none_pending)
    );

    // Hypervisor restore through the frame; it wins over guest mirrors
    assign hyp_vm_wr = reg_sel_i && reg_wr_i &&
        (reg_addr_i == `VCI_OFF_VMCTL);

    // Priority mask follows the guest's mask writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_priority_mask <=
                VM_RESET_WORD[`VCI_VM_PMASK_HI:`VCI_VM_PMASK_LO];
        end else if (hyp_vm_wr) begin
            virt_priority_mask <=
                reg_wdata_i[`VCI_VM_PMASK_HI:`VCI_VM_PMASK_LO];
        end else if (guest_pmask_wr_i) begin
            virt_priority_mask <= guest_wdata_i[7:0];
        end
    end

    // Group 0 binary point follows the guest's binary point writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_binary_point_g0 <=
                VM_RESET_WORD[`VCI_VM_BP0_HI:`VCI_VM_BP0_LO];
        end else if (hyp_vm_wr) begin
            virt_binary_point_g0 <=
                reg_wdata_i[`VCI_VM_BP0_HI:`VCI_VM_BP0_LO];
        end else if (guest_binpoint_wr_i) begin
            virt_binary_point_g0 <= guest_wdata_i[2:0];
        end
    end

    // Group 1 binary point follows the aliased binary point writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_binary_point_g1 <=
                VM_RESET_WORD[`VCI_VM_BP1_HI:`VCI_VM_BP1_LO];
        end else if (hyp_vm_wr) begin
            virt_binary_point_g1 <=
                reg_wdata_i[`VCI_VM_BP1_HI:`VCI_VM_BP1_LO];
        end else if (guest_alias_binpoint_wr_i) begin
            virt_binary_point_g1 <= guest_wdata_i[2:0];
        end
    end

    // Split mode; with SPLIT_RAO the bit is pinned high, even after reset
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_eoi_split_mode <= VM_RESET_WORD[`VCI_VM_SPLIT] | SPLIT_RAO;
        end else if (SPLIT_RAO) begin
            virt_eoi_split_mode <= 1'b1;
        end else if (hyp_vm_wr) begin
            virt_eoi_split_mode <= reg_wdata_i[`VCI_VM_SPLIT];
        end else if (guest_ctl_wr_i) begin
            virt_eoi_split_mode <= guest_wdata_i[9];
        end
    end

    // Common binary point; guest control layout puts it at bit 4
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_common_binpoint <= VM_RESET_WORD[`VCI_VM_CBP];
        end else if (hyp_vm_wr) begin
            virt_common_binpoint <= reg_wdata_i[`VCI_VM_CBP];
        end else if (guest_ctl_wr_i) begin
            virt_common_binpoint <= guest_wdata_i[4];
        end
    end

    // Fast interrupt select from guest control bit 3
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_fast_irq_select <= VM_RESET_WORD[`VCI_VM_FIQ];
        end else if (hyp_vm_wr) begin
            virt_fast_irq_select <= reg_wdata_i[`VCI_VM_FIQ];
        end else if (guest_ctl_wr_i) begin
            virt_fast_irq_select <= guest_wdata_i[3];
        end
    end

    // Acknowledge control from guest control bit 2
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_ack_control <= VM_RESET_WORD[`VCI_VM_ACK];
        end else if (hyp_vm_wr) begin
            virt_ack_control <= reg_wdata_i[`VCI_VM_ACK];
        end else if (guest_ctl_wr_i) begin
            virt_ack_control <= guest_wdata_i[2];
        end
    end

    // Group 1 enable from guest control bit 1
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_group1_enable <= VM_RESET_WORD[`VCI_VM_G1EN];
        end else if (hyp_vm_wr) begin
            virt_group1_enable <= reg_wdata_i[`VCI_VM_G1EN];
        end else if (guest_ctl_wr_i) begin
            virt_group1_enable <= guest_wdata_i[1];
        end
    end

    // Group 0 enable from guest control bit 0
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            virt_group0_enable <= VM_RESET_WORD[`VCI_VM_G0EN];
        end else if (hyp_vm_wr) begin
            virt_group0_enable <= reg_wdata_i[`VCI_VM_G0EN];
        end else if (guest_ctl_wr_i) begin
            virt_group0_enable <= guest_wdata_i[0];
        end
    end

    // Register view; reserved bits hold no storage, so they read zero
    always_comb begin
        vm_control_alias = 32'h00000000;
        vm_control_alias[`VCI_VM_PMASK_HI:`VCI_VM_PMASK_LO] =
            virt_priority_mask;
        vm_control_alias[`VCI_VM_BP0_HI:`VCI_VM_BP0_LO] =
            virt_binary_point_g0;
        vm_control_alias[`VCI_VM_BP1_HI:`VCI_VM_BP1_LO] =
            virt_binary_point_g1;
        vm_control_alias[`VCI_VM_SPLIT] = virt_eoi_split_mode;
        vm_control_alias[`VCI_VM_CBP] = virt_common_binpoint;
        vm_control_alias[`VCI_VM_FIQ] = virt_fast_irq_select;
        vm_control_alias[`VCI_VM_ACK] = virt_ack_control;
        vm_control_alias[`VCI_VM_G1EN] = virt_group1_enable;
        vm_control_alias[`VCI_VM_G0EN] = virt_group0_enable;
    end

    // Status is a pure function of its causes, sampled each clock
    always_comb begin
        next_status = 8'h00;
        next_status[`VCI_MS_EOI] = |eoi_status_vector_i;
        next_status[`VCI_MS_UNDER] =
            underflow_irq_enable_i & le_one_valid;
        next_status[`VCI_MS_ABSENT] = list_entry_absent_irq_enable_i &
            (end_of_irq_counter_i != 5'h00);
        next_status[`VCI_MS_NOPEND] =
            no_pending_irq_enable_i & none_pending;
        next_status[`VCI_MS_G0EN] =
            group0_state_irq_enable_i & virt_group0_enable;
        next_status[`VCI_MS_G0DIS] =
            group0_state_irq_enable_i & ~virt_group0_enable;
        next_status[`VCI_MS_G1EN] =
            group1_state_irq_enable_i & virt_group1_enable;
        next_status[`VCI_MS_G1DIS] =
            group1_state_irq_enable_i & ~virt_group1_enable;
    end

    // Registered so a read and the interrupt agree on one value
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            maintenance_irq_status <= 8'h00;
        end else begin
            maintenance_irq_status <= next_status;
        end
    end

    // Maintenance request gated by the global enable
    assign maint_irq_o =
        (|maintenance_irq_status) & hyp_global_enable_i;

    // Type register is fixed at build time
    assign virtual_type_info = {
        `VCI_PRI_M1,
        `VCI_PRE_M1,
        `VCI_IDW_16,
        `VCI_SEI_SUP,
        `VCI_AFF3_SUP,
        16'h0000,
        5'(`VCI_NUM_LR - 1)
    };

    // Read mux; unmapped offsets return zero
    always_comb begin
        case (reg_addr_i)
            `VCI_OFF_TYPE: next_rdata = virtual_type_info;
            `VCI_OFF_VMCTL: next_rdata = vm_control_alias;
            `VCI_OFF_MSTAT: next_rdata = {24'h000000, maintenance_irq_status};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read strobe; the held data only changes on a read
    assign hyp_rd = reg_sel_i && !reg_wr_i;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (hyp_rd) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Lower number means higher priority, so strictly below the mask
    assign above_mask = cand_priority_i < virt_priority_mask;
    assign group_on = cand_group1_i ? virt_group1_enable
                                    : virt_group0_enable;
    assign virt_fiq_o = cand_valid_i & above_mask & group_on &
        ~cand_group1_i & virt_fast_irq_select;
    assign virt_irq_o = cand_valid_i & above_mask & group_on &
        (cand_group1_i | ~virt_fast_irq_select);

    // Acknowledge value seen by the guest
    assign ack_id_o = (cand_group1_i && !virt_ack_control) ?
        `VCI_SPURIOUS_ID : cand_id_i;

    // Binary point governing group 1
    assign group1_binpoint_o = virt_common_binpoint ?
        virt_binary_point_g0 : virt_binary_point_g1;
    assign eoi_deactivates_o = ~virt_eoi_split_mode;
endmodule
`default_nettype wire

// file: bench/vci_ctrl_regs_monitor.sv
// Assertion checker for the virtual interface control registers
`default_nettype none
module vci_ctrl_regs_monitor (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic reg_sel_i,
    input wire logic reg_wr_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic hyp_global_enable_i,
    input wire logic list_entry_absent_irq_enable_i,
    input wire logic [4:0] end_of_irq_counter_i,
    input wire logic [31:0] eoi_status_vector_i,
    input wire logic cand_valid_i,
    input wire logic cand_group1_i,
    input wire logic [9:0] cand_id_i,
    input wire logic maint_irq_o,
    input wire logic virt_irq_o,
    input wire logic virt_fiq_o,
    input wire logic [9:0] ack_id_o,
    input wire logic [2:0] group1_binpoint_o,
    input wire logic eoi_deactivates_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Register frame accesses that the checks key on
    sequence s_vm_wr;
        reg_sel_i && reg_wr_i && reg_addr_i == 12'h008;
    endsequence
    sequence s_rd(a);
        reg_sel_i && !reg_wr_i && reg_addr_i == a;
    endsequence
    // Status lags its cause by one cycle, so the enable must hold across
    property p_eoi;
        (|eoi_status_vector_i) && hyp_global_enable_i ##1
            hyp_global_enable_i |-> maint_irq_o;
    endproperty
    property p_absent;
        list_entry_absent_irq_enable_i && end_of_irq_counter_i != 5'h00
            && hyp_global_enable_i ##1 hyp_global_enable_i |-> maint_irq_o;
    endproperty
    property p_gate;
        !hyp_global_enable_i |-> !maint_irq_o;
    endproperty
    property p_ack;
        cand_valid_i |-> ack_id_o == cand_id_i
            || (cand_group1_i && ack_id_o == 10'h3fe);
    endproperty
    property p_fiq;
        virt_fiq_o |-> cand_valid_i && !cand_group1_i;
    endproperty
    property p_irq;
        virt_irq_o |-> cand_valid_i && !virt_fiq_o;
    endproperty
    property p_split;
        s_vm_wr |=> eoi_deactivates_o != $past(reg_wdata_i[9]);
    endproperty
    property p_bp;
        s_vm_wr |=> group1_binpoint_o == ($past(reg_wdata_i[4]) ?
            $past(reg_wdata_i[23:21]) : $past(reg_wdata_i[20:18]));
    endproperty
    property p_vm_rsv;
        s_rd(12'h008) |=> reg_rdata_o[17:10] == 8'h00
            && reg_rdata_o[8:5] == 4'h0;
    endproperty
    property p_typ_rsv;
        s_rd(12'h004) |=> reg_rdata_o[20:5] == 16'h0000;
    endproperty
    a_eoi: assert property (p_eoi) else $error("eoi status missed");
    a_absent: assert property (p_absent) else $error("absent missed");
    a_gate: assert property (p_gate) else $error("maint not gated");
    a_ack: assert property (p_ack) else $error("ack id wrong");
    a_fiq: assert property (p_fiq) else $error("fiq wrong");
    a_irq: assert property (p_irq) else $error("irq wrong");
    a_split: assert property (p_split) else $error("split bad");
    a_bp: assert property (p_bp) else $error("binpoint bad");
    a_vm_rsv: assert property (p_vm_rsv) else $error("vm rsv");
    a_typ_rsv: assert property (p_typ_rsv) else $error("type rsv");
endmodule
bind vci_ctrl_regs vci_ctrl_regs_monitor vci_ctrl_regs_monitor_inst (.*);
`default_nettype wire

// file: bench/vci_ctrl_regs_tb_top.sv
// Self-checking bench for the virtual interface control registers
`default_nettype none
`include "vci_consts.svh"
module vci_ctrl_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, sel, wr, ge, ae, ue, ne, cv, cg, mi, vi, vf, ed;
    logic g0e, g1e;
    logic [3:0] gpw;
    logic [11:0] addr;
    logic [31:0] wd, rd, ev, gd, vm, r, lw, typ;
    logic [31:0] rs = 32'h49f1d863;
    logic [4:0] ec;
    logic [7:0] cp;
    logic [9:0] ci, aid;
    logic [2:0] bp;
    logic [`VCI_NUM_LR*32-1:0] le;
    logic [11:0] tbl [4] = '{12'h008, 12'h004, 12'h010, 12'h00c};
    logic [31:0] ex [4];
    int n_errors, n_checks, cyc;
    vci_ctrl_regs vci_ctrl_regs_inst (.core_clk_i(clk), .arst_n_i(rst_n),
        .reg_sel_i(sel), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rd), .hyp_global_enable_i(ge),
        .list_entry_absent_irq_enable_i(ae), .underflow_irq_enable_i(ue),
        .no_pending_irq_enable_i(ne), .group0_state_irq_enable_i(g0e),
        .group1_state_irq_enable_i(g1e), .end_of_irq_counter_i(ec),
        .eoi_status_vector_i(ev), .list_entry_reg_i(le),
        .guest_pmask_wr_i(gpw[0]), .guest_binpoint_wr_i(gpw[1]),
        .guest_alias_binpoint_wr_i(gpw[2]), .guest_ctl_wr_i(gpw[3]),
        .guest_wdata_i(gd), .cand_valid_i(cv), .cand_group1_i(cg),
        .cand_priority_i(cp), .cand_id_i(ci), .maint_irq_o(mi),
        .virt_irq_o(vi), .virt_fiq_o(vf), .ack_id_o(aid),
        .group1_binpoint_o(bp), .eoi_deactivates_o(ed));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // Status model; bits 7:4 follow the group enables of the model word
    function automatic logic [31:0] stat_exp();
        int nv = 0;
        logic np = 1'b1;
        for (int i = 0; i < `VCI_NUM_LR; i++) begin
            if (le[i*32+28 +: 2] != 2'h0) nv++;
            if (le[i*32+28 +: 2] == 2'h1) np = 1'b0;
        end
        return {24'h0, g1e & !vm[1], g1e & vm[1], g0e & !vm[0],
                g0e & vm[0], ne & np, ae & (ec != 5'h00), ue & (nv <= 1),
                |ev};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One register access; read data is valid just after the edge that takes it
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        sel <= 1'b0;
        #1;
    endtask
    // Guest-side update pulse, mirrored into the model
    task automatic gw(input int k, input logic [31:0] d);
        @(posedge clk);
        gpw <= 4'h1 << k;
        gd <= d;
        @(posedge clk);
        gpw <= 4'h0;
        case (k)
            0: vm[31:24] = d[7:0];
            1: vm[23:21] = d[2:0];
            2: vm[20:18] = d[2:0];
            default: {vm[9], vm[4:0]} = {d[9], d[4:0]};
        endcase
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Run length guard: the tests need well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        {sel, wr, ge, ae, ue, ne, cv, cg, gpw, addr, wd, ev, gd} = '0;
        {ec, cp, ci, le, g0e, g1e} = '0;
        vm = `VCI_VM_RESET;
        typ = {`VCI_PRI_M1, `VCI_PRE_M1, 3'h0, `VCI_SEI_SUP, `VCI_AFF3_SUP,
               16'h0000, 5'(`VCI_NUM_LR - 1)};
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then writes to every place and read-back
        for (int i = 0; i < 12; i++) begin
            ex = '{vm, typ, 32'h0, 32'h0};
            acc(1'b0, tbl[i % 4], 32'h0);
            chk(rd, ex[i % 4]);
            lw = rnd();
            acc(1'b1, tbl[i % 4], lw);
            if (i % 4 == 0) vm = lw & `VCI_VM_MASK;
        end
        $display("test register map done");
        for (int i = 0; i < 8; i++) begin
            gw(i % 4, rnd());
            acc(1'b0, 12'h008, 32'h0);
            chk(rd, vm);
        end
        $display("test guest mirror done");
        for (int i = 0; i < 16; i++) begin
            // Causes change on a rising edge, then status gets time to settle
            @(posedge clk);
            r = rnd();
            for (int j = 0; j < `VCI_NUM_LR; j++) begin
                lw = rnd();
                if (r[12+j]) lw[29:28] = 2'h0;
                le[j*32 +: 32] <= lw;
            end
            ev <= r[0] ? rnd() : 32'h0;
            {ae, ue, ne, ge} <= r[4:1];
            {g1e, g0e} <= r[11:10];
            ec <= r[0] ? 5'h00 : r[9:5];
            repeat (2) @(posedge clk);
            acc(1'b0, 12'h010, 32'h0);
            chk(rd, stat_exp());
            chk(mi, (stat_exp() != 0) & ge);
        end
        $display("test status done");
        for (int i = 0; i < 24; i++) begin
            gw(i % 4, rnd());
            r = rnd();
            cv <= r[0];
            cg <= r[1];
            cp <= r[9:2];
            ci <= r[19:10];
            @(posedge clk);
            #1;
            lw[0] = cv && cp < vm[31:24] && (cg ? vm[1] : vm[0]);
            lw[1] = lw[0] && (cg || !vm[3]);
            lw[2] = lw[0] && !cg && vm[3];
            lw[5:3] = vm[4] ? vm[23:21] : vm[20:18];
            chk({vi, vf}, {lw[1], lw[2]});
            chk(aid, (cg && !vm[2]) ? 10'h3fe : ci);
            chk({ed, bp}, {!vm[9], lw[5:3]});
        end
        $display("test candidate done");
        summarize();
    end
endmodule
`default_nettype wire
